//--- common/radio_cfg_pkg.sv
// Purpose: Shared constants and types for the radio channel configuration block
// Assumes: 64 physical channels, 250 MHz clock
// Notes: Parameter selectors are the command codes seen on the host port
package radio_cfg_pkg;

    // ************************************************
    // Sizes
    // ************************************************
    localparam int NUM_CHAN = 64;
    localparam int CNT_W = 7;
    localparam int CLK_HZ = 250000000;
    localparam int SCAN_MS_CYCLES = CLK_HZ / 1000;

    // ************************************************
    // Command selectors
    // ************************************************
    localparam logic [2:0] SEL_CHAN_MASK = 3'h0;
    localparam logic [2:0] SEL_PREAMBLE = 3'h1;
    localparam logic [2:0] SEL_NET_TAG = 3'h2;
    localparam logic [2:0] SEL_BCAST_REP = 3'h3;
    localparam logic [2:0] SEL_TX_POWER = 3'h4;
    localparam logic [2:0] SEL_RETRY = 3'h5;
    localparam logic [2:0] SEL_SCAN = 3'h6;
    localparam logic [2:0] SEL_MIN_COUNT = 3'h7;

    // ************************************************
    // Reset values and ranges
    // ************************************************
    localparam logic [63:0] MASK_RESET = 64'hFFFF_FFFF_FFF7_FFFF;
    localparam logic [6:0] MIN_COUNT_DEFAULT = 7'h19;
    localparam logic [6:0] MIN_COUNT_SG = 7'h0B;
    localparam logic [2:0] PREAMBLE_RESET = 3'h0;
    localparam logic [63:0] PREAMBLE_MAX = 64'h7;
    localparam logic [14:0] NET_TAG_RESET = 15'h7FFF;
    localparam logic [63:0] NET_TAG_MAX = 64'h7FFF;
    localparam logic [63:0] NET_TAG_FACTORY_CODE = 64'hFFFF;
    localparam logic [2:0] BCAST_REP_RESET = 3'h3;
    localparam logic [63:0] BCAST_REP_MAX = 64'h5;
    localparam logic [2:0] TX_POWER_RESET = 3'h4;
    localparam logic [63:0] TX_POWER_MAX = 64'h4;
    localparam logic [3:0] RETRY_RESET = 4'hF;
    localparam logic [63:0] RETRY_MAX = 64'hF;
    localparam logic [7:0] SCAN_DUR_RESET = 8'h10;
    localparam logic [63:0] SCAN_DUR_MAX = 64'hFF;
    localparam logic [7:0] ENERGY_FLOOR = 8'hFF;

    // ************************************************
    // Report characters
    // ************************************************
    localparam logic [7:0] CHAR_COMMA = 8'h2C;
    localparam logic [7:0] CHAR_CR = 8'h0D;

    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_REPORT} scan_state_t;

endpackage

//--- logic/active_channel_select.sv
// Purpose: Picks the lowest eligible channels up to the minimum count
// Assumes: Inputs come from logic on the same clock
// Notes: Purely combinational
module active_channel_select (
    // Channel sets
    input wire logic [radio_cfg_pkg::NUM_CHAN-1:0] enable_mask,
    input wire logic [radio_cfg_pkg::NUM_CHAN-1:0] avail_map,
    input wire logic [radio_cfg_pkg::CNT_W-1:0] min_count,
    // Results
    output logic [radio_cfg_pkg::NUM_CHAN-1:0] active,
    output logic [radio_cfg_pkg::CNT_W-1:0] eligible_count
);
    import radio_cfg_pkg::*;

    logic [CNT_W-1:0] prefix [0:NUM_CHAN];
    logic [NUM_CHAN-1:0] eligible;

    assign prefix[0] = '0;

    genvar i;
    generate
        for (i = 0; i < NUM_CHAN; i++) begin : g_chan
            assign eligible[i] = enable_mask[i] & avail_map[i];
            assign prefix[i+1] = prefix[i] + {{(CNT_W-1){1'b0}}, eligible[i]};
            assign active[i] = eligible[i] && (prefix[i] < min_count);
        end
    endgenerate

    assign eligible_count = prefix[NUM_CHAN];

endmodule

//--- logic/radio_mac_channel_config.sv
// Purpose: Parameter store, receive filter, transmit policy and energy scan
// Assumes: All inputs come from logic on the clk domain
// Notes: One command answered per cycle, response one cycle later
//
// How it works
// - A channel is eligible only when its mask bit and map bit are both one.
// - A mask leaving fewer eligible channels than the minimum count is refused.
// - Only the lowest eligible channels, up to the minimum count, become active.
// - Minimum count is read-only, 1 to 50, 25 normally, 11 for Singapore.
// - The mask leaves reset with channel 19 disabled.
// - A 3-bit preamble code, reset zero, must match for communication.
// - Receive checks the preamble code first, then the network tag.
// - Network tag 0 to 0x7FFF, reset 0x7FFF, must match to accept.
// - With vendor tags enabled, writing 0xFFFF loads the factory tag.
// - Broadcasts go out repeat count plus one times; count 0 to 5, reset 3.
// - Power codes 0 to 4 give +7 to +24 dBm; reset 4, the calibrated one.
// - A non-zero retry limit makes unicasts request acknowledgment.
// - Unacknowledged unicasts are resent up to the retry limit, 0 to 0xF.
// - Energy scan runs for its millisecond duration, looping all channels.
// - Scan report lists lowest energy reading per channel, comma separated, ends in CR.
// - Map bit n is channel n, lowest frequency at bit 0, 400 kHz steps.
module radio_mac_channel_config #(
    parameter int MS_CYCLES = radio_cfg_pkg::SCAN_MS_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Configuration straps
    input wire logic region_singapore,
    input wire logic vendor_tags_enable,
    input wire logic [14:0] factory_tag,
    input wire logic [radio_cfg_pkg::NUM_CHAN-1:0] available_channel_map,
    // Host command port
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_sel,
    input wire logic [63:0] cmd_data,
    output logic resp_valid,
    output logic resp_error,
    // Current settings
    output logic [radio_cfg_pkg::NUM_CHAN-1:0] channel_enable_mask,
    output logic [radio_cfg_pkg::NUM_CHAN-1:0] active_channels,
    output logic [6:0] min_channel_count,
    output logic [2:0] preamble_code,
    output logic [14:0] network_tag,
    output logic [2:0] broadcast_repeat_count,
    output logic [2:0] tx_power_select,
    output logic [3:0] unicast_retry_limit,
    // Receive filter
    input wire logic rx_hdr_valid,
    input wire logic [2:0] rx_preamble,
    input wire logic [14:0] rx_tag,
    output logic rx_accept,
    output logic rx_reject,
    // Transmit policy
    input wire logic tx_req,
    input wire logic tx_broadcast,
    output logic tx_plan_valid,
    output logic tx_ack_request,
    output logic [4:0] tx_attempts,
    // Energy scan
    input wire logic [7:0] energy_in,
    output logic scan_busy,
    output logic [5:0] scan_channel,
    output logic rpt_valid,
    output logic [7:0] rpt_char,
    input wire logic rpt_ready
);
    import radio_cfg_pkg::*;

    // ************************************************
    // State
    // ************************************************
    logic strap_taken_reg;
    logic [6:0] min_count_reg;
    logic [NUM_CHAN-1:0] mask_reg;
    logic [NUM_CHAN-1:0] active_reg;
    logic [2:0] preamble_reg;
    logic [14:0] tag_reg;
    logic [2:0] bcast_reg;
    logic [2:0] power_reg;
    logic [3:0] retry_reg;
    logic resp_valid_reg;
    logic resp_error_reg;
    logic rx_accept_reg;
    logic rx_reject_reg;
    logic tx_plan_valid_reg;
    logic tx_ack_reg;
    logic [4:0] tx_attempts_reg;
    scan_state_t state_reg;
    logic [5:0] chan_reg;
    logic [7:0] ms_left_reg;
    logic [31:0] tick_reg;
    logic [7:0] peak_mem [0:NUM_CHAN-1];
    logic [5:0] rpt_chan_reg;
    logic [1:0] rpt_phase_reg;
    logic rpt_valid_reg;
    logic [7:0] rpt_char_reg;

    // ************************************************
    // Command decode
    // ************************************************
    logic [NUM_CHAN-1:0] cand_active;
    logic [CNT_W-1:0] cand_count;
    logic [NUM_CHAN-1:0] cur_active;
    logic [CNT_W-1:0] cur_count;
    logic tag_factory;
    logic cmd_ok;
    logic wr_mask;
    logic wr_pre;
    logic wr_tag;
    logic wr_bcast;
    logic wr_power;
    logic wr_retry;
    logic start_scan;

    active_channel_select cand_sel (
        .enable_mask(cmd_data),
        .avail_map(available_channel_map),
        .min_count(min_count_reg),
        .active(cand_active),
        .eligible_count(cand_count)
    );

    active_channel_select cur_sel (
        .enable_mask(mask_reg),
        .avail_map(available_channel_map),
        .min_count(min_count_reg),
        .active(cur_active),
        .eligible_count(cur_count)
    );

    assign tag_factory = vendor_tags_enable && (cmd_data == NET_TAG_FACTORY_CODE);
    assign cmd_ok = (cmd_sel == SEL_CHAN_MASK) ? (cand_count >= min_count_reg) :
                    (cmd_sel == SEL_PREAMBLE) ? (cmd_data <= PREAMBLE_MAX) :
                    (cmd_sel == SEL_NET_TAG) ? (cmd_data <= NET_TAG_MAX) || tag_factory :
                    (cmd_sel == SEL_BCAST_REP) ? (cmd_data <= BCAST_REP_MAX) :
                    (cmd_sel == SEL_TX_POWER) ? (cmd_data <= TX_POWER_MAX) :
                    (cmd_sel == SEL_RETRY) ? (cmd_data <= RETRY_MAX) :
                    (cmd_sel == SEL_SCAN) ? (cmd_data <= SCAN_DUR_MAX) && (state_reg == ST_IDLE) :
                    1'b0;
    assign wr_mask = cmd_valid && cmd_ok && (cmd_sel == SEL_CHAN_MASK);
    assign wr_pre = cmd_valid && cmd_ok && (cmd_sel == SEL_PREAMBLE);
    assign wr_tag = cmd_valid && cmd_ok && (cmd_sel == SEL_NET_TAG);
    assign wr_bcast = cmd_valid && cmd_ok && (cmd_sel == SEL_BCAST_REP);
    assign wr_power = cmd_valid && cmd_ok && (cmd_sel == SEL_TX_POWER);
    assign wr_retry = cmd_valid && cmd_ok && (cmd_sel == SEL_RETRY);
    assign start_scan = cmd_valid && cmd_ok && (cmd_sel == SEL_SCAN);

    // ************************************************
    // Region strap and settings
    // ************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strap_taken_reg <= 1'b0;
            min_count_reg <= MIN_COUNT_DEFAULT;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            min_count_reg <= region_singapore ? MIN_COUNT_SG : MIN_COUNT_DEFAULT;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mask_reg <= MASK_RESET;
            preamble_reg <= PREAMBLE_RESET;
            tag_reg <= NET_TAG_RESET;
            bcast_reg <= BCAST_REP_RESET;
            power_reg <= TX_POWER_RESET;
            retry_reg <= RETRY_RESET;
        end else begin
            if (wr_mask) mask_reg <= cmd_data;
            if (wr_pre) preamble_reg <= cmd_data[2:0];
            if (wr_tag) tag_reg <= tag_factory ? factory_tag : cmd_data[14:0];
            if (wr_bcast) bcast_reg <= cmd_data[2:0];
            if (wr_power) power_reg <= cmd_data[2:0];
            if (wr_retry) retry_reg <= cmd_data[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resp_valid_reg <= 1'b0;
            resp_error_reg <= 1'b0;
            active_reg <= '0;
        end else begin
            resp_valid_reg <= cmd_valid;
            resp_error_reg <= cmd_valid && !cmd_ok;
            active_reg <= cur_active;
        end
    end

    // ************************************************
    // Receive filter and transmit policy
    // ************************************************
    logic pre_match;
    logic tag_match;

    assign pre_match = (rx_preamble == preamble_reg);
    assign tag_match = pre_match && (rx_tag == tag_reg);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_accept_reg <= 1'b0;
            rx_reject_reg <= 1'b0;
            tx_plan_valid_reg <= 1'b0;
            tx_ack_reg <= 1'b0;
            tx_attempts_reg <= 5'h0;
        end else begin
            rx_accept_reg <= rx_hdr_valid && tag_match;
            rx_reject_reg <= rx_hdr_valid && !tag_match;
            tx_plan_valid_reg <= tx_req;
            if (tx_req) begin
                tx_ack_reg <= !tx_broadcast && (retry_reg != 4'h0);
                tx_attempts_reg <= tx_broadcast ? {2'h0, bcast_reg} + 5'h1 :
                                   {1'h0, retry_reg} + 5'h1;
            end
        end
    end

    // ************************************************
    // Energy scan and report
    // ************************************************
    logic tick_done;
    logic rpt_take;
    logic [3:0] nib;
    logic [7:0] hex_char;
    logic [7:0] cur_peak;

    assign tick_done = (tick_reg == 32'(MS_CYCLES - 1));
    assign rpt_take = !rpt_valid_reg || rpt_ready;
    assign cur_peak = peak_mem[rpt_chan_reg];
    assign nib = (rpt_phase_reg == 2'h0) ? cur_peak[7:4] : cur_peak[3:0];
    assign hex_char = (nib < 4'hA) ? 8'h30 + {4'h0, nib} : 8'h37 + {4'h0, nib};

    always_ff @(posedge clk) begin
        if (state_reg == ST_IDLE && start_scan) begin
            for (int k = 0; k < NUM_CHAN; k++) peak_mem[k] <= ENERGY_FLOOR;
        end else if (state_reg == ST_SCAN && energy_in < peak_mem[chan_reg]) begin
            peak_mem[chan_reg] <= energy_in;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            chan_reg <= 6'h0;
            ms_left_reg <= SCAN_DUR_RESET;
            tick_reg <= 32'h0;
            rpt_chan_reg <= 6'h0;
            rpt_phase_reg <= 2'h0;
            rpt_valid_reg <= 1'b0;
            rpt_char_reg <= 8'h00;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_scan) begin
                        ms_left_reg <= cmd_data[7:0];
                        chan_reg <= 6'h0;
                        tick_reg <= 32'h0;
                        state_reg <= (cmd_data[7:0] == 8'h00) ? ST_REPORT : ST_SCAN;
                        rpt_chan_reg <= 6'h0;
                        rpt_phase_reg <= 2'h0;
                    end
                end
                ST_SCAN: begin
                    chan_reg <= chan_reg + 6'h1;
                    tick_reg <= tick_done ? 32'h0 : tick_reg + 32'h1;
                    if (tick_done) begin
                        ms_left_reg <= ms_left_reg - 8'h1;
                        if (ms_left_reg == 8'h1) state_reg <= ST_REPORT;
                    end
                end
                ST_REPORT: begin
                    if (rpt_take) begin
                        rpt_valid_reg <= 1'b1;
                        if (rpt_phase_reg == 2'h2) begin
                            rpt_char_reg <= (rpt_chan_reg == 6'h3F) ? CHAR_CR : CHAR_COMMA;
                            rpt_phase_reg <= 2'h0;
                            rpt_chan_reg <= rpt_chan_reg + 6'h1;
                            if (rpt_chan_reg == 6'h3F) state_reg <= ST_IDLE;
                        end else begin
                            rpt_char_reg <= hex_char;
                            rpt_phase_reg <= rpt_phase_reg + 2'h1;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
            if (state_reg != ST_REPORT && rpt_valid_reg && rpt_ready) rpt_valid_reg <= 1'b0;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign resp_valid = resp_valid_reg;
    assign resp_error = resp_error_reg;
    assign channel_enable_mask = mask_reg;
    assign active_channels = active_reg;
    assign min_channel_count = min_count_reg;
    assign preamble_code = preamble_reg;
    assign network_tag = tag_reg;
    assign broadcast_repeat_count = bcast_reg;
    assign tx_power_select = power_reg;
    assign unicast_retry_limit = retry_reg;
    assign rx_accept = rx_accept_reg;
    assign rx_reject = rx_reject_reg;
    assign tx_plan_valid = tx_plan_valid_reg;
    assign tx_ack_request = tx_ack_reg;
    assign tx_attempts = tx_attempts_reg;
    assign scan_busy = (state_reg != ST_IDLE);
    assign scan_channel = chan_reg;
    assign rpt_valid = rpt_valid_reg;
    assign rpt_char = rpt_char_reg;

endmodule

//--- testbench/radio_cfg_props.sv
// Purpose: Port assertions for radio_mac_channel_config
// Assumes: One clock, synchronous active-high reset
// Notes: Bound from the bench top file
module radio_cfg_props (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Command port
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_sel,
    input wire logic [63:0] cmd_data,
    input wire logic resp_valid,
    input wire logic resp_error,
    // Settings
    input wire logic [radio_cfg_pkg::NUM_CHAN-1:0] channel_enable_mask,
    input wire logic [radio_cfg_pkg::NUM_CHAN-1:0] available_channel_map,
    input wire logic [radio_cfg_pkg::NUM_CHAN-1:0] active_channels,
    input wire logic [6:0] min_channel_count,
    input wire logic [2:0] preamble_code,
    input wire logic [14:0] network_tag,
    input wire logic [2:0] broadcast_repeat_count,
    input wire logic [2:0] tx_power_select,
    input wire logic [3:0] unicast_retry_limit,
    // Receive, transmit and scan
    input wire logic rx_hdr_valid,
    input wire logic [2:0] rx_preamble,
    input wire logic [14:0] rx_tag,
    input wire logic rx_accept,
    input wire logic rx_reject,
    input wire logic tx_req,
    input wire logic tx_broadcast,
    input wire logic tx_plan_valid,
    input wire logic tx_ack_request,
    input wire logic [4:0] tx_attempts,
    input wire logic scan_busy
);
    import radio_cfg_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_resp_follows: assert property (cmd_valid |=> resp_valid)
        else $error("command got no response");
    a_min_readonly: assert property (cmd_valid && cmd_sel == SEL_MIN_COUNT
        |=> resp_error && $stable(min_channel_count)) else $error("min count written");
    a_preamble_range: assert property (cmd_valid && cmd_sel == SEL_PREAMBLE
        && cmd_data > PREAMBLE_MAX |=> resp_error && $stable(preamble_code))
        else $error("preamble out of range taken");
    a_power_range: assert property (cmd_valid && cmd_sel == SEL_TX_POWER
        && cmd_data > TX_POWER_MAX |=> resp_error && $stable(tx_power_select))
        else $error("power out of range taken");
    a_active_eligible: assert property ((active_channels &
        ~($past(channel_enable_mask) & $past(available_channel_map))) == '0)
        else $error("ineligible channel active");
    a_bcast_plan: assert property (tx_req && tx_broadcast |=> tx_plan_valid
        && !tx_ack_request && tx_attempts == 5'($past(broadcast_repeat_count)) + 5'h01)
        else $error("broadcast plan wrong");
    a_unicast_plan: assert property (tx_req && !tx_broadcast |=> tx_plan_valid
        && tx_ack_request == ($past(unicast_retry_limit) != 4'h0)
        && tx_attempts == 5'($past(unicast_retry_limit)) + 5'h01)
        else $error("unicast plan wrong");
    a_rx_filter: assert property (rx_hdr_valid |=>
        rx_accept == ($past(rx_preamble) == $past(preamble_code)
        && $past(rx_tag) == $past(network_tag)) && rx_reject == !rx_accept)
        else $error("receive filter wrong");
    a_scan_starts: assert property (cmd_valid && cmd_sel == SEL_SCAN && !scan_busy
        && cmd_data <= SCAN_DUR_MAX |=> scan_busy && !resp_error)
        else $error("scan did not start");
    a_mask_reset: assert property ($fell(sys_rst) |-> !channel_enable_mask[19])
        else $error("channel 19 enabled after reset");
endmodule

//--- testbench/peer_node_model.sv
// Purpose: Peer side stand-in for channel energy and report traffic
// Assumes: Same clock as the block
// Notes: Slow mode takes one report char in four cycles
module peer_node_model (
    // Clock and mode
    input wire logic clk,
    input wire logic fast,
    // Scan side
    input wire logic [5:0] scan_channel,
    output logic [7:0] energy_in,
    // Report side
    input wire logic rpt_valid,
    input wire logic [7:0] rpt_char,
    output logic rpt_ready
);
    logic [1:0] stall_reg = 2'h0;
    logic ready_reg = 1'b0;
    logic [7:0] chars[$];
    assign energy_in = {2'h1, scan_channel}; // Same hop channel as the block
    assign rpt_ready = ready_reg;
    always_ff @(posedge clk) begin
        stall_reg <= stall_reg + 2'h1;
        ready_reg <= fast || (stall_reg == 2'h3);
        if (rpt_valid && rpt_ready) begin
            chars.push_back(rpt_char);
        end
    end
endmodule

//--- testbench/tb_radio_mac_channel_config.sv
// Purpose: Self-checking bench for radio_mac_channel_config
// Assumes: MS_CYCLES shortened to 8
// Notes: Command rows first, then corner cases, then reset
module tb_radio_mac_channel_config import radio_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [2:0] sel; logic [63:0] data; logic err;} row_t;
    localparam row_t ROWS [14] = '{'{SEL_PREAMBLE, 64'h5, 1'b0}, '{SEL_PREAMBLE, 64'h8, 1'b1},
        '{SEL_NET_TAG, 64'h1234, 1'b0}, '{SEL_NET_TAG, 64'h8000, 1'b1},
        '{SEL_NET_TAG, 64'hFFFF, 1'b1}, '{SEL_BCAST_REP, 64'h0, 1'b0},
        '{SEL_BCAST_REP, 64'h6, 1'b1}, '{SEL_TX_POWER, 64'h0, 1'b0},
        '{SEL_TX_POWER, 64'h5, 1'b1}, '{SEL_RETRY, 64'h0, 1'b0}, '{SEL_RETRY, 64'h10, 1'b1},
        '{SEL_MIN_COUNT, 64'h5, 1'b1}, '{SEL_CHAN_MASK, 64'h00FF_FFFF, 1'b1},
        '{SEL_CHAN_MASK, 64'hFFFF_0000_3FFF_FFFF, 1'b0}};
    localparam logic [63:0] RST_SET [8] = '{MASK_RESET, 64'(PREAMBLE_RESET),
        64'(NET_TAG_RESET), 64'(BCAST_REP_RESET), 64'(TX_POWER_RESET), 64'(RETRY_RESET),
        64'h0, 64'(MIN_COUNT_DEFAULT)};
    logic [63:0] exp_set [8] = RST_SET;
    logic clk = 1'b0, sys_rst = 1'b1, region_singapore = 1'b0, vendor_tags_enable = 1'b0;
    logic [14:0] factory_tag = 15'h2A5A, rx_tag = 15'h0, network_tag;
    logic [63:0] available_channel_map = 64'hFFFF_FFFF, cmd_data = 64'h0;
    logic cmd_valid = 1'b0, rx_hdr_valid = 1'b0, tx_req = 1'b0, tx_broadcast = 1'b0;
    logic fast = 1'b0;
    logic [2:0] cmd_sel = 3'h0, rx_preamble = 3'h0;
    logic resp_valid, resp_error, rx_accept, rx_reject, tx_plan_valid, tx_ack_request;
    logic scan_busy, rpt_valid, rpt_ready;
    logic [63:0] channel_enable_mask, active_channels;
    logic [6:0] min_channel_count;
    logic [2:0] preamble_code, broadcast_repeat_count, tx_power_select;
    logic [3:0] unicast_retry_limit;
    logic [4:0] tx_attempts;
    logic [7:0] energy_in, rpt_char;
    logic [5:0] scan_channel;
    int n_errors = 0;
    int cmp_count = 0;
    always #2 clk = ~clk;
    radio_mac_channel_config #(.MS_CYCLES(8)) u_dut (.clk, .sys_rst, .region_singapore,
        .vendor_tags_enable, .factory_tag, .available_channel_map, .cmd_valid, .cmd_sel,
        .cmd_data, .resp_valid, .resp_error, .channel_enable_mask, .active_channels,
        .min_channel_count, .preamble_code, .network_tag, .broadcast_repeat_count,
        .tx_power_select, .unicast_retry_limit, .rx_hdr_valid, .rx_preamble, .rx_tag,
        .rx_accept, .rx_reject, .tx_req, .tx_broadcast, .tx_plan_valid, .tx_ack_request,
        .tx_attempts, .energy_in, .scan_busy, .scan_channel, .rpt_valid, .rpt_char,
        .rpt_ready);
    peer_node_model u_peer (.clk, .fast, .scan_channel, .energy_in, .rpt_valid, .rpt_char,
        .rpt_ready);
    // ************************************************
    // Tasks
    // ************************************************
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic [63:0] setting(input logic [2:0] sel);
        case (sel)
            SEL_CHAN_MASK: return channel_enable_mask;
            SEL_PREAMBLE: return 64'(preamble_code);
            SEL_NET_TAG: return 64'(network_tag);
            SEL_BCAST_REP: return 64'(broadcast_repeat_count);
            SEL_TX_POWER: return 64'(tx_power_select);
            SEL_RETRY: return 64'(unicast_retry_limit);
            default: return 64'(min_channel_count);
        endcase
    endfunction
    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction
    function automatic logic [7:0] rpt_exp(input int k);
        logic [7:0] p;
        p = 8'h40 + 8'(k / 3);
        if (k % 3 == 0) return hexc(p[7:4]);
        if (k % 3 == 1) return hexc(p[3:0]);
        return (k == 191) ? CHAR_CR : CHAR_COMMA;
    endfunction
    task automatic send(input logic [2:0] sel, input logic [63:0] data, input logic err);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_sel <= sel;
        cmd_data <= data;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        chk("resp_valid", 64'h1, 64'(resp_valid));
        chk("resp_error", 64'(err), 64'(resp_error));
    endtask
    task automatic rx(input logic [2:0] pre, input logic [14:0] tag, input logic acc);
        @(posedge clk);
        rx_hdr_valid <= 1'b1;
        rx_preamble <= pre;
        rx_tag <= tag;
        @(posedge clk);
        rx_hdr_valid <= 1'b0;
        #1;
        chk("rx_accept", 64'(acc), 64'(rx_accept));
        chk("rx_reject", 64'(!acc), 64'(rx_reject));
    endtask
    task automatic tx(input logic bc, input logic ack, input logic [4:0] att);
        @(posedge clk);
        tx_req <= 1'b1;
        tx_broadcast <= bc;
        @(posedge clk);
        tx_req <= 1'b0;
        #1;
        chk("tx_plan_valid", 64'h1, 64'(tx_plan_valid));
        chk("tx_ack_request", 64'(ack), 64'(tx_ack_request));
        chk("tx_attempts", 64'(att), 64'(tx_attempts));
    endtask
    // ************************************************
    // Sequence
    // ************************************************
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        foreach (ROWS[i]) begin
            send(ROWS[i].sel, ROWS[i].data, ROWS[i].err);
            if (!ROWS[i].err) exp_set[ROWS[i].sel] = ROWS[i].data;
            chk("setting", exp_set[ROWS[i].sel], setting(ROWS[i].sel));
        end
        repeat (2) @(posedge clk);
        chk("active_channels", 64'h01FF_FFFF, active_channels);
        for (int i = 0; i < 5; i++) begin
            send(SEL_TX_POWER, 64'(i), 1'b0);
            chk("tx_power_select", 64'(i), 64'(tx_power_select));
        end
        rx(3'h5, 15'h1234, 1'b1);
        rx(3'h4, 15'h1234, 1'b0);
        rx(3'h5, 15'h1235, 1'b0);
        tx(1'b1, 1'b0, 5'h01);
        tx(1'b0, 1'b0, 5'h01);
        send(SEL_RETRY, 64'h3, 1'b0);
        tx(1'b0, 1'b1, 5'h04);
        @(posedge clk);
        vendor_tags_enable <= 1'b1;
        send(SEL_NET_TAG, 64'hFFFF, 1'b0);
        chk("network_tag", 64'h2A5A, 64'(network_tag));
        send(SEL_SCAN, 64'h8, 1'b0);
        send(SEL_SCAN, 64'h1, 1'b1);
        for (int i = 0; i < 5000 && u_peer.chars.size() < 192; i++) @(posedge clk);
        if (u_peer.chars.size() < 192) begin
            n_errors++;
            tally_and_finish();
        end
        for (int k = 0; k < 192; k++) begin
            chk("report char", 64'(rpt_exp(k)), 64'(u_peer.chars[k]));
        end
        fast <= 1'b1;
        send(SEL_SCAN, 64'h0, 1'b0);
        repeat (4) @(posedge clk);
        chk("zero scan char", 64'h46, 64'(u_peer.chars[192]));
        // Singapore strap; preamble codes 1 to 3 stay unused from here on
        @(posedge clk);
        sys_rst <= 1'b1;
        region_singapore <= 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        for (int s = 0; s < 6; s++) begin
            chk("reset value", RST_SET[s], setting(3'(s)));
        end
        chk("min_channel_count", 64'(MIN_COUNT_SG), 64'(min_channel_count));
        tally_and_finish();
    end
endmodule
bind radio_mac_channel_config radio_cfg_props u_props (.clk, .sys_rst, .cmd_valid,
    .cmd_sel, .cmd_data, .resp_valid, .resp_error, .channel_enable_mask,
    .available_channel_map, .active_channels, .min_channel_count, .preamble_code,
    .network_tag, .broadcast_repeat_count, .tx_power_select, .unicast_retry_limit,
    .rx_hdr_valid, .rx_preamble, .rx_tag, .rx_accept, .rx_reject, .tx_req, .tx_broadcast,
    .tx_plan_valid, .tx_ack_request, .tx_attempts, .scan_busy);
